// ===== uart_interrupt_enable_identify.sv
// Purpose: Interrupt enable, prioritising and identification for a UART
// Assumes: All inputs on mclk; receiver, transmitter and queues live outside
// Notes: Owns the enable, divisor high byte and queue-enable bits; rest of map is outside
module uart_interrupt_enable_identify
  import uieid_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire uieid_req_t cpuReq,
  input wire logic divisor_access_select,
  input wire logic lineStatusRead,
  input wire uieid_src_t src,
  output logic [31:0] cpuRdata,
  output logic cpuRvalid,
  output logic cpuIrq,
  output logic [7:0] divisor_high_byte,
  output logic fifoControlWrite,
  output logic [7:0] fifoControlData,
  output logic rxBufferRead,
  output logic txHoldingWrite
);

  logic [EN_WIDTH-1:0] enable_q;
  logic [7:0] divHigh_q;
  logic queueMode_q;
  logic overrun_q;
  logic txEmptyPend_q;
  logic txEmptyPrev_q;
  logic [2:0] idleCount_q;
  logic timeout_q;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic irq_q;
  logic fcWrite_q;
  logic [7:0] fcData_q;
  logic [31:0] identWord;
  logic [31:0] enableWord;
  logic [2:0] sourceCode;
  logic anyPending;
  logic lsPend;
  logic rxPend;
  logic toPend;
  logic txPend;
  logic wrEnable;
  logic wrDivHigh;
  logic wrIdent;
  logic rxPop;
  logic txLoad;
  logic rxActivity;

  // Address decode of the CPU port
  always_comb begin
    wrEnable = cpuReq.wr && cpuReq.addr == OFS_ENABLE && !divisor_access_select;
    wrDivHigh = cpuReq.wr && ((cpuReq.addr == OFS_ENABLE && divisor_access_select) ||
                              cpuReq.addr == OFS_DIV_HIGH);
    wrIdent = cpuReq.wr && cpuReq.addr == OFS_IDENT;
    rxPop = cpuReq.rd && cpuReq.addr == OFS_DATA && !divisor_access_select;
    txLoad = cpuReq.wr && cpuReq.addr == OFS_DATA && !divisor_access_select;
    rxActivity = rxPop || src.rxPush;
  end

  assign rxBufferRead = rxPop;
  assign txHoldingWrite = txLoad;

  // Interrupt enable register, only the three defined bits are stored
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      enable_q <= EN_RESET;
    end else if (wrEnable) begin
      enable_q <= cpuReq.wdata[EN_WIDTH-1:0];
    end
  end

  // Divisor high byte, reachable at shared and dedicated addresses
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      divHigh_q <= DIV_HIGH_RESET;
    end else if (wrDivHigh) begin
      divHigh_q <= cpuReq.wdata[7:0];
    end
  end

  // Queue control write: keep the queue enable bit, pass the byte on
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      queueMode_q <= 1'b0;
      fcWrite_q <= 1'b0;
      fcData_q <= 8'h00;
    end else begin
      fcWrite_q <= wrIdent;
      if (wrIdent) begin
        queueMode_q <= cpuReq.wdata[FC_QUEUE_EN];
        fcData_q <= cpuReq.wdata[7:0];
      end
    end
  end

  // Overrun flag: set wins over the clear by a line status read
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      overrun_q <= 1'b0;
    end else if (src.overrunEvent) begin
      overrun_q <= 1'b1;
    end else if (lineStatusRead) begin
      overrun_q <= 1'b0;
    end
  end

  // Transmit empty flag: set on becoming empty, cleared by a transmit load
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      txEmptyPrev_q <= 1'b0;
      txEmptyPend_q <= 1'b0;
    end else begin
      txEmptyPrev_q <= src.txEmpty;
      if (src.txEmpty && !txEmptyPrev_q) begin
        txEmptyPend_q <= 1'b1;
      end else if (txLoad) begin
        txEmptyPend_q <= 1'b0;
      end
    end
  end

  // Character timeout: count idle character times while data is held
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      idleCount_q <= 3'h0;
      timeout_q <= 1'b0;
    end else if (!queueMode_q || !src.rxQueueHolding || rxActivity) begin
      idleCount_q <= 3'h0;
      timeout_q <= 1'b0;
    end else if (src.charTick && !timeout_q) begin
      if (idleCount_q == TIMEOUT_LAST) begin
        timeout_q <= 1'b1;
      end else begin
        idleCount_q <= idleCount_q + 3'h1;
      end
    end
  end

  // Enabled sources and priority encoding
  always_comb begin
    lsPend = (overrun_q || src.errorDataHeld) && enable_q[EN_LINE_STATUS];
    rxPend = (queueMode_q ? src.rxAtTrigger : src.rxDataReady) && enable_q[EN_RX_DATA];
    toPend = timeout_q && enable_q[EN_RX_DATA];
    txPend = txEmptyPend_q && enable_q[EN_TX_EMPTY];
    anyPending = lsPend || rxPend || toPend || txPend;
    if (lsPend) begin
      sourceCode = CODE_LINE_STATUS;
    end else if (rxPend) begin
      sourceCode = CODE_RX_DATA;
    end else if (toPend) begin
      sourceCode = CODE_TIMEOUT;
    end else if (txPend) begin
      sourceCode = CODE_TX_EMPTY;
    end else begin
      sourceCode = CODE_NONE;
    end
  end

  // Identification and enable words as read back
  always_comb begin
    identWord = WORD_ZERO;
    identWord[ID_PEND] = !anyPending;
    identWord[ID_CODE_HI:ID_CODE_LO] = sourceCode;
    identWord[ID_QUEUE_HI:ID_QUEUE_LO] = queueMode_q ? QUEUE_ON : QUEUE_OFF;
    enableWord = WORD_ZERO;
    enableWord[EN_WIDTH-1:0] = enable_q;
  end

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata_q <= WORD_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= cpuReq.rd;
      if (cpuReq.rd) begin
        case (cpuReq.addr)
          OFS_ENABLE: begin
            rdata_q <= divisor_access_select ? {24'h000000, divHigh_q} : enableWord;
          end
          OFS_IDENT: begin
            rdata_q <= identWord;
          end
          OFS_DIV_HIGH: begin
            rdata_q <= {24'h000000, divHigh_q};
          end
          default: begin
            rdata_q <= WORD_ZERO;
          end
        endcase
      end
    end
  end

  // Request line to the CPU
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= anyPending;
    end
  end

  assign cpuRdata = rdata_q;
  assign cpuRvalid = rvalid_q;
  assign cpuIrq = irq_q;
  assign divisor_high_byte = divHigh_q;
  assign fifoControlWrite = fcWrite_q;
  assign fifoControlData = fcData_q;

endmodule

// ===== uieid_pkg.sv
// Purpose: Shared constants and types for the UART interrupt enable/identify block
// Assumes: 32-bit register words at byte offsets, 6-bit byte address
// Notes: Offsets are byte addresses of the UART register map
package uieid_pkg;

  // Register byte offsets
  localparam logic [5:0] OFS_DATA = 6'h00;
  localparam logic [5:0] OFS_ENABLE = 6'h04;
  localparam logic [5:0] OFS_IDENT = 6'h08;
  localparam logic [5:0] OFS_DIV_HIGH = 6'h24;

  // Interrupt enable field positions
  localparam int EN_RX_DATA = 0;
  localparam int EN_TX_EMPTY = 1;
  localparam int EN_LINE_STATUS = 2;
  localparam int EN_WIDTH = 3;
  localparam logic [EN_WIDTH-1:0] EN_RESET = 3'h0;

  // Identification field positions and codes
  localparam int ID_PEND = 0;
  localparam int ID_CODE_LO = 1;
  localparam int ID_CODE_HI = 3;
  localparam int ID_QUEUE_LO = 6;
  localparam int ID_QUEUE_HI = 7;
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_TX_EMPTY = 3'h1;
  localparam logic [2:0] CODE_RX_DATA = 3'h2;
  localparam logic [2:0] CODE_LINE_STATUS = 3'h3;
  localparam logic [2:0] CODE_TIMEOUT = 3'h6;
  localparam logic [1:0] QUEUE_OFF = 2'h0;
  localparam logic [1:0] QUEUE_ON = 2'h3;

  // Queue control field: queue enable bit
  localparam int FC_QUEUE_EN = 0;

  // Character times of receive idle before timeout
  localparam int TIMEOUT_CHARS = 4;
  localparam logic [2:0] TIMEOUT_LAST = 3'(TIMEOUT_CHARS - 1);

  // Reset values
  localparam logic [7:0] DIV_HIGH_RESET = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  // Status from the receiver, transmitter and queues, all on mclk
  typedef struct packed {
    logic overrunEvent;   // One-cycle pulse: overrun detected
    logic errorDataHeld;  // Level: parity/framing/break data still unread
    logic rxDataReady;    // Level: non-queue receive buffer full
    logic rxAtTrigger;    // Level: receive queue at or above trigger
    logic rxQueueHolding; // Level: receive queue holds at least one character
    logic rxPush;         // One-cycle pulse: character entered receive queue
    logic txEmpty;        // Level: holding register or transmit queue empty
    logic charTick;       // One-cycle pulse per character time
  } uieid_src_t;

  // CPU register port request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [31:0] wdata;
  } uieid_req_t;

endpackage

// ===== uieid_chk_sva.sv
// Purpose: Port checker for the interrupt enable/identify block
// Assumes: One mclk domain, synchronous active-low reset
// Notes: Bound to every instance of the block
module uieid_chk
  import uieid_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire uieid_req_t cpuReq,
  input wire logic divisor_access_select,
  input wire logic [31:0] cpuRdata,
  input wire logic cpuIrq,
  input wire logic cpuRvalid,
  input wire logic [7:0] divisor_high_byte,
  input wire logic fifoControlWrite,
  input wire logic [7:0] fifoControlData,
  input wire logic rxBufferRead,
  input wire logic txHoldingWrite
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Decoded reads of the ident and enable words
  logic rdId;
  logic rdEn;
  assign rdId = cpuReq.rd && cpuReq.addr == OFS_IDENT;
  assign rdEn = cpuReq.rd && cpuReq.addr == OFS_ENABLE && !divisor_access_select;
  // Shadow of queue mode and enable bits as last written by the CPU
  logic qMode_q;
  logic [EN_WIDTH-1:0] enShadow_q;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      qMode_q <= 1'b0;
      enShadow_q <= EN_RESET;
    end else begin
      if (cpuReq.wr && cpuReq.addr == OFS_IDENT) begin
        qMode_q <= cpuReq.wdata[FC_QUEUE_EN];
      end
      if (cpuReq.wr && cpuReq.addr == OFS_ENABLE && !divisor_access_select) begin
        enShadow_q <= cpuReq.wdata[EN_WIDTH-1:0];
      end
    end
  end
  AST_RST_QUIET: assert property (disable iff (1'b0) !reset_n |=> !cpuIrq && !cpuRvalid)
    else $error("active after reset");
  AST_ID_RSV: assert property (rdId |=> cpuRvalid && cpuRdata[31:8] == 24'h0 && cpuRdata[5:4] == 2'h0)
    else $error("ident reserved bits");
  AST_PEND_IRQ: assert property (rdId |=> cpuRdata[ID_PEND] == !cpuIrq)
    else $error("pending vs request");
  AST_CODE: assert property (rdId |=> cpuRdata[ID_PEND] == (cpuRdata[3:1] == CODE_NONE))
    else $error("code vs pending");
  AST_QUEUE: assert property (rdId |=> cpuRdata[7:6] == ($past(qMode_q) ? QUEUE_ON : QUEUE_OFF))
    else $error("queue field");
  AST_NO_EN: assert property (enShadow_q == '0 |=> !cpuIrq)
    else $error("request with nothing enabled");
  AST_TX_LOAD: assert property (txHoldingWrite ==
    (cpuReq.wr && cpuReq.addr == OFS_DATA && !divisor_access_select))
    else $error("transmit load strobe");
  AST_RX_POP: assert property (rxBufferRead ==
    (cpuReq.rd && cpuReq.addr == OFS_DATA && !divisor_access_select))
    else $error("receive buffer read strobe");
  AST_EN_RD: assert property (rdEn |=> cpuRdata[31:3] == 29'h0)
    else $error("enable high bits");
  AST_FC_WR: assert property (cpuReq.wr && cpuReq.addr == OFS_IDENT
    |=> fifoControlWrite && fifoControlData == $past(cpuReq.wdata[7:0]))
    else $error("queue control write");
  AST_DIV_WR: assert property (cpuReq.wr && (cpuReq.addr == OFS_DIV_HIGH || cpuReq.addr == OFS_ENABLE
    && divisor_access_select) |=> divisor_high_byte == $past(cpuReq.wdata[7:0]))
    else $error("divisor high write");
endmodule
bind uart_interrupt_enable_identify uieid_chk i_uieid_chk (.mclk, .reset_n, .cpuReq,
  .divisor_access_select, .cpuRdata, .cpuIrq, .cpuRvalid, .divisor_high_byte,
  .fifoControlWrite, .fifoControlData, .rxBufferRead, .txHoldingWrite);

// ===== uieid_cpu_model.sv
// Purpose: CPU model driving the register port
// Assumes: Requests launched by non-blocking assignment at mclk rising edge
// Notes: Read data is taken once the answer has landed
module uieid_cpu_model
  import uieid_pkg::*;
(
  input wire logic mclk,
  input wire logic [31:0] cpuRdata,
  output uieid_req_t cpuReq
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cpuReq = '0;
  // One-cycle write; reserved enable bit 3 always written as zero
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    cpuReq <= '{1'b0, 1'b1, a, (a == OFS_ENABLE) ? (d & ~32'h8) : d};
    @(posedge mclk);
    cpuReq <= '0;
  endtask
  // One-cycle read; data is taken in the cycle after it becomes valid
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge mclk);
    cpuReq <= '{1'b1, 1'b0, a, 32'h0};
    @(posedge mclk);
    cpuReq <= '0;
    @(posedge mclk);
    d = cpuRdata;
  endtask
endmodule

// ===== tb.sv
// Purpose: Directed test of the interrupt enable/identify block
// Assumes: 25 MHz mclk, reset held 20 cycles
// Notes: Register traffic goes through the CPU model
module tb
  import uieid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic dsel = 1'b0;
  logic lsRead = 1'b0;
  uieid_src_t src = '0;
  uieid_req_t cpuReq;
  logic [31:0] cpuRdata;
  logic [31:0] rdat;
  logic cpuIrq;
  int n_fail = 0;
  int check_count = 0;
  always #20 mclk = ~mclk;
  uart_interrupt_enable_identify i_uart_interrupt_enable_identify (.mclk(mclk), .reset_n(reset_n),
    .cpuReq(cpuReq), .divisor_access_select(dsel), .lineStatusRead(lsRead), .src(src),
    .cpuRdata(cpuRdata), .cpuRvalid(), .cpuIrq(cpuIrq), .divisor_high_byte(), .fifoControlWrite(),
    .fifoControlData(), .rxBufferRead(), .txHoldingWrite());
  uieid_cpu_model i_uieid_cpu_model (.mclk(mclk), .cpuRdata(cpuRdata), .cpuReq(cpuReq));
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    i_uieid_cpu_model.wr(a, d);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    i_uieid_cpu_model.rd(a, rdat);
    chk(rdat, exp);
  endtask
  // One-cycle pulse on source bits and on the status-read strobe
  task automatic pulse(input logic [7:0] m, input logic ls);
    cyc(1);
    src <= src | m;
    lsRead <= ls;
    cyc(1);
    src <= src & ~m;
    lsRead <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    cyc(5000);
    chk(32'h0, 32'h1);
    end_of_test();
  end
  initial begin
    cyc(20);
    reset_n <= 1'b1;
    rdc(OFS_IDENT, 32'h1);
    rdc(OFS_ENABLE, 32'h0);
    rdc(6'h0c, 32'h0);
    wr(OFS_ENABLE, 32'hffffffff);
    rdc(OFS_ENABLE, 32'h7);
    cyc(1);
    src.txEmpty <= 1'b1;
    cyc(3);
    rdc(OFS_IDENT, 32'h2);
    chk({31'h0, cpuIrq}, 32'h1);
    wr(OFS_DATA, 32'h41);
    rdc(OFS_IDENT, 32'h1);
    $display("reset and tx test done");
    cyc(1);
    src.rxDataReady <= 1'b1;
    pulse(8'h80, 1'b0);
    rdc(OFS_IDENT, 32'h6);
    pulse(8'h00, 1'b1);
    rdc(OFS_IDENT, 32'h4);
    wr(OFS_ENABLE, 32'h0);
    pulse(8'h80, 1'b0);
    rdc(OFS_IDENT, 32'h1);
    chk({31'h0, cpuIrq}, 32'h0);
    wr(OFS_ENABLE, 32'h4);
    rdc(OFS_IDENT, 32'h6);
    pulse(8'h00, 1'b1);
    rdc(OFS_IDENT, 32'h1);
    wr(OFS_ENABLE, 32'h1);
    rdc(OFS_IDENT, 32'h4);
    $display("gating test done");
    cyc(1);
    dsel <= 1'b1;
    wr(OFS_ENABLE, 32'ha5);
    rdc(OFS_ENABLE, 32'ha5);
    rdc(OFS_IDENT, 32'h4);
    wr(OFS_IDENT, 32'h1);
    cyc(1);
    dsel <= 1'b0;
    src.rxDataReady <= 1'b0;
    src.rxQueueHolding <= 1'b1;
    rdc(OFS_DIV_HIGH, 32'ha5);
    rdc(OFS_ENABLE, 32'h1);
    rdc(OFS_IDENT, 32'hc1);
    repeat (3) pulse(8'h01, 1'b0);
    rdc(OFS_IDENT, 32'hc1);
    pulse(8'h01, 1'b0);
    rdc(OFS_IDENT, 32'hcc);
    i_uieid_cpu_model.rd(OFS_DATA, rdat);
    rdc(OFS_IDENT, 32'hc1);
    wr(OFS_ENABLE, 32'h5);
    src.rxAtTrigger <= 1'b1;
    rdc(OFS_IDENT, 32'hc4);
    src.errorDataHeld <= 1'b1;
    rdc(OFS_IDENT, 32'hc6);
    src.errorDataHeld <= 1'b0;
    rdc(OFS_IDENT, 32'hc4);
    src.rxAtTrigger <= 1'b0;
    rdc(OFS_IDENT, 32'hc1);
    repeat (3) pulse(8'h01, 1'b0);
    pulse(8'h04, 1'b0);
    pulse(8'h01, 1'b0);
    rdc(OFS_IDENT, 32'hc1);
    repeat (3) pulse(8'h01, 1'b0);
    rdc(OFS_IDENT, 32'hcc);
    $display("select and queue test done");
    reset_n <= 1'b0;
    cyc(2);
    reset_n <= 1'b1;
    rdc(OFS_IDENT, 32'h1);
    rdc(OFS_ENABLE, 32'h0);
    rdc(OFS_DIV_HIGH, 32'h0);
    wr(OFS_ENABLE, 32'h2);
    rdc(OFS_IDENT, 32'h2);
    $display("second reset test done");
    end_of_test();
  end
endmodule
